// [design/pcwp_port.sv]
// pcwp_port: byte-wide configuration write port, device end
// assumes: host drives config_clock, chip select, write strobe and data;
// ref_clk_i is several times faster than config_clock
`timescale 1ns/1ps

module pcwp_port #(
    parameter int unsigned SINK_LAT = pcwp_pkg::SINK_LAT_RST,
    parameter int unsigned ABORT_CYC = pcwp_pkg::ABORT_CYC_RST,
    parameter logic [31:0] SYNC_WORD = pcwp_pkg::SYNC_WORD_RST
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic config_clock_i,
    input wire logic cs_n_i,
    input wire logic write_n_i,
    input wire logic [pcwp_pkg::DATA_W-1:0] config_data_byte_i,
    output logic busy_o,
    output logic byte_valid_o,
    output logic [pcwp_pkg::DATA_W-1:0] byte_data_o,
    output logic aligned_o,
    output logic abort_o
);

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    pcwp_pkg::pcwp_pins_t pins_raw;
    pcwp_pkg::pcwp_pins_t pins_s;
    pcwp_pkg::pcwp_pins_t pins_rst;

    assign pins_raw = '{cs_n: cs_n_i, write_n: write_n_i,
                        clk: config_clock_i, data: config_data_byte_i};
    assign pins_rst = '{cs_n: 1'b1, write_n: 1'b1, clk: 1'b0,
                        data: 8'h00};

    pcwp_sync #(
        .WIDTH($bits(pcwp_pkg::pcwp_pins_t))
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .async_i(pins_raw),
        .rst_val_i(pins_rst),
        .sync_o(pins_s)
    );

    // ------------------------------------------------------------
    // config_clock edge detection and period measurement
    // ------------------------------------------------------------
    logic clk_d_r;
    logic clk_d_nxt;
    logic [pcwp_pkg::PERIOD_W-1:0] per_cnt_r;
    logic [pcwp_pkg::PERIOD_W-1:0] per_cnt_nxt;
    logic fast_r;
    logic fast_nxt;
    logic rise;

    assign rise = pins_s.clk && !clk_d_r;

    always_comb
    begin
        clk_d_nxt = pins_s.clk;
        per_cnt_nxt = per_cnt_r;
        fast_nxt = fast_r;
        if (rise)
        begin
            per_cnt_nxt = 8'h01;
            // fast clock means period at or under the no-handshake period
            fast_nxt = (per_cnt_r <=
                pcwp_pkg::PERIOD_W'(pcwp_pkg::FAST_PERIOD_CYC));
        end
        else if (per_cnt_r != pcwp_pkg::PERIOD_MAX)
        begin
            per_cnt_nxt = per_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            clk_d_r <= 1'b0;
            per_cnt_r <= pcwp_pkg::PERIOD_MAX;
            fast_r <= 1'b0;
        end
        else
        begin
            clk_d_r <= clk_d_nxt;
            per_cnt_r <= per_cnt_nxt;
            fast_r <= fast_nxt;
        end
    end

    // ------------------------------------------------------------
    // write handshake, abort and alignment
    // ------------------------------------------------------------
    function automatic logic [31:0] shift_in(input logic [31:0] w,
                                            input logic [7:0] b);
        shift_in = {w[23:0], b};
    endfunction : shift_in

    pcwp_pkg::pcwp_state_t state_r;
    pcwp_pkg::pcwp_state_t state_nxt;
    logic [7:0] sink_cnt_r;
    logic [7:0] sink_cnt_nxt;
    logic busy_r;
    logic busy_nxt;
    logic aligned_r;
    logic aligned_nxt;
    logic [31:0] shreg_r;
    logic [31:0] shreg_nxt;
    logic [1:0] byte_idx_r;
    logic [1:0] byte_idx_nxt;
    pcwp_pkg::pcwp_byte_t out_r;
    pcwp_pkg::pcwp_byte_t out_nxt;
    logic abort_r;
    logic abort_nxt;
    logic selected;
    logic take;

    assign selected = !pins_s.cs_n;
    // busy is sampled as it stood before this rise
    assign take = rise && selected && !pins_s.write_n && !busy_r;

    always_comb
    begin
        state_nxt = state_r;
        sink_cnt_nxt = sink_cnt_r;
        busy_nxt = busy_r;
        aligned_nxt = aligned_r;
        shreg_nxt = shreg_r;
        byte_idx_nxt = byte_idx_r;
        out_nxt = '{valid: 1'b0, data: out_r.data};
        abort_nxt = 1'b0;
        case (state_r)
            pcwp_pkg::ST_IDLE:
            begin
                if (rise && selected && !pins_s.write_n)
                begin
                    state_nxt = pcwp_pkg::ST_WRITE;
                end
            end
            pcwp_pkg::ST_WRITE, pcwp_pkg::ST_WAIT:
            begin
                if (!selected)
                begin
                    // releasing select ends a pending wait as well
                    state_nxt = pcwp_pkg::ST_IDLE;
                    busy_nxt = 1'b0;
                end
                else if (rise && pins_s.write_n)
                begin
                    // strobe dropped under select: direction change
                    state_nxt = pcwp_pkg::ST_ABORT;
                    sink_cnt_nxt = 8'(ABORT_CYC);
                    busy_nxt = 1'b1;
                    aligned_nxt = 1'b0;
                    byte_idx_nxt = 2'b00;
                    abort_nxt = 1'b1;
                end
                else if (state_r == pcwp_pkg::ST_WAIT)
                begin
                    // byte held off while busy stays high
                    if (sink_cnt_r <= 8'h01)
                    begin
                        busy_nxt = 1'b0;
                        state_nxt = pcwp_pkg::ST_WRITE;
                    end
                    else
                    begin
                        sink_cnt_nxt = sink_cnt_r - 8'h01;
                    end
                end
            end
            pcwp_pkg::ST_ABORT:
            begin
                // busy held through the whole abort, not cut short by cs
                if (sink_cnt_r <= 8'h01)
                begin
                    busy_nxt = 1'b0;
                    state_nxt = pcwp_pkg::ST_IDLE;
                end
                else
                begin
                    sink_cnt_nxt = sink_cnt_r - 8'h01;
                end
            end
            default:
            begin
                state_nxt = pcwp_pkg::ST_IDLE;
                busy_nxt = 1'b0;
            end
        endcase
        // the rise that opens a burst carries its first byte too
        if (take)
        begin
            shreg_nxt = shift_in(shreg_r, pins_s.data);
            if (aligned_r)
            begin
                // packets only pass once sync word is seen
                out_nxt = '{valid: 1'b1, data: pins_s.data};
                byte_idx_nxt = byte_idx_r + 2'b01;
            end
            else if (shift_in(shreg_r, pins_s.data) == SYNC_WORD)
            begin
                aligned_nxt = 1'b1;
                byte_idx_nxt = 2'b00;
            end
            // internal sink needs time only when clock is fast
            if (fast_r)
            begin
                busy_nxt = 1'b1;
                sink_cnt_nxt = 8'(SINK_LAT);
                state_nxt = pcwp_pkg::ST_WAIT;
            end
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            state_r <= pcwp_pkg::ST_IDLE;
            sink_cnt_r <= 8'h00;
            busy_r <= 1'b0;
            aligned_r <= 1'b0;
            shreg_r <= 32'h00000000;
            byte_idx_r <= 2'b00;
            out_r <= '{valid: 1'b0, data: 8'h00};
            abort_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            sink_cnt_r <= sink_cnt_nxt;
            busy_r <= busy_nxt;
            aligned_r <= aligned_nxt;
            shreg_r <= shreg_nxt;
            byte_idx_r <= byte_idx_nxt;
            out_r <= out_nxt;
            abort_r <= abort_nxt;
        end
    end

    assign busy_o = busy_r;
    assign byte_valid_o = out_r.valid;
    assign byte_data_o = out_r.data;
    assign aligned_o = aligned_r;
    assign abort_o = abort_r;

endmodule : pcwp_port

// [design/pcwp_pkg.sv]
// pcwp_pkg: shared constants and carrier types for the parallel config port
// assumes: nothing beyond a standard SystemVerilog compiler
package pcwp_pkg;

    // ------------------------------------------------------------
    // timing figures
    // ------------------------------------------------------------
    localparam int unsigned REF_CLK_HZ = 25000000;
    localparam int unsigned MAX_FREQ_MHZ = 66;
    localparam int unsigned NO_HANDSHAKE_FREQ_LIMIT_MHZ = 50;
    // config_clock period at the no-handshake limit, in ns (rounded down)
    localparam int unsigned NO_HANDSHAKE_PERIOD_NS =
        1000 / NO_HANDSHAKE_FREQ_LIMIT_MHZ;
    localparam int unsigned REF_PERIOD_NS = 1000000000 / REF_CLK_HZ;
    // sampled config_clock period (ref cycles) at or below which it is "fast";
    // at 25 MHz sampling this is at least one cycle
    localparam int unsigned FAST_PERIOD_CYC =
        (NO_HANDSHAKE_PERIOD_NS / REF_PERIOD_NS) < 1 ? 1 :
        (NO_HANDSHAKE_PERIOD_NS / REF_PERIOD_NS);

    // ------------------------------------------------------------
    // data layout and defaults
    // ------------------------------------------------------------
    localparam int unsigned DATA_W = 8;
    localparam int unsigned WORD_BYTES = 4;
    localparam logic [31:0] SYNC_WORD_RST = 32'haa995566;
    localparam int unsigned SINK_LAT_RST = 2;
    localparam int unsigned ABORT_CYC_RST = 4;
    localparam int unsigned PERIOD_W = 8;
    localparam logic [PERIOD_W-1:0] PERIOD_MAX = 8'hff;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic cs_n;
        logic write_n;
        logic clk;
        logic [DATA_W-1:0] data;
    } pcwp_pins_t;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } pcwp_byte_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_WRITE = 4'b0010,
        ST_WAIT  = 4'b0100,
        ST_ABORT = 4'b1000
    } pcwp_state_t;

endpackage : pcwp_pkg

// [design/pcwp_sync.sv]
// pcwp_sync: two-flop synchroniser for the port's pin inputs
// assumes: inputs are asynchronous to ref_clk_i
`timescale 1ns/1ps
module pcwp_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [WIDTH-1:0] async_i,
    input wire logic [WIDTH-1:0] rst_val_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    always_comb
    begin
        meta_nxt = async_i;
        sync_nxt = meta_r;
    end

    // reset value is a constant tie at the instance, synchronous reset
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            meta_r <= rst_val_i;
            sync_r <= rst_val_i;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_o = sync_r;

endmodule : pcwp_sync

// [sim/pcwp_monitor.sv]
// pcwp_monitor: port-level checks of pcwp_port
// assumes: config_clock far slower than ref_clk_i
`timescale 1ns/1ps
module pcwp_monitor #(
    parameter int unsigned SINK_LAT = pcwp_pkg::SINK_LAT_RST,
    parameter int unsigned ABORT_CYC = pcwp_pkg::ABORT_CYC_RST
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic config_clock_i,
    input wire logic cs_n_i,
    input wire logic write_n_i,
    input wire logic [7:0] config_data_byte_i,
    input wire logic busy_o,
    input wire logic byte_valid_o,
    input wire logic [7:0] byte_data_o,
    input wire logic aligned_o,
    input wire logic abort_o
);
    logic [7:0] run_r;
    logic [7:0] run_nxt;
    always_comb
    begin
        run_nxt = busy_o ? run_r + 8'h01 : 8'h00;
    end
    always_ff @(posedge ref_clk_i)
    begin
        run_r <= resetn_i ? run_nxt : 8'h00;
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    property p_accept;
        $rose(config_clock_i) && !cs_n_i && !write_n_i && !busy_o
            && aligned_o |-> ##[1:5] byte_valid_o;
    endproperty
    a_accept: assert property (p_accept) else $error("byte lost");
    property p_aligned;
        byte_valid_o |-> aligned_o;
    endproperty
    a_aligned: assert property (p_aligned) else $error("bad pass");
    property p_abort;
        $rose(config_clock_i) && !cs_n_i && write_n_i |-> ##[1:5] abort_o;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort");
    property p_unalign;
        abort_o |-> !aligned_o;
    endproperty
    a_unalign: assert property (p_unalign) else $error("kept align");
    property p_ab_busy;
        abort_o |-> busy_o;
    endproperty
    a_ab_busy: assert property (p_ab_busy) else $error("not busy");
    property p_busy_len;
        $fell(busy_o) |-> run_r == ABORT_CYC || run_r == SINK_LAT;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy len");
    property p_one;
        byte_valid_o |=> !byte_valid_o;
    endproperty
    a_one: assert property (p_one) else $error("double byte");
    property p_slow;
        $rose(busy_o) |-> abort_o || byte_valid_o;
    endproperty
    a_slow: assert property (p_slow) else $error("stray busy");
endmodule : pcwp_monitor
bind pcwp_port pcwp_monitor u_mon (.ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .config_clock_i(config_clock_i), .cs_n_i(cs_n_i),
    .write_n_i(write_n_i), .config_data_byte_i(config_data_byte_i),
    .busy_o(busy_o), .byte_valid_o(byte_valid_o),
    .byte_data_o(byte_data_o), .aligned_o(aligned_o), .abort_o(abort_o));

// [sim/pcwp_host_model.sv]
// pcwp_host_model: configuration host driving the port pins
// assumes: called from tb; pins change at ref_clk falling edges
`timescale 1ns/1ps
module pcwp_host_model (
    input wire logic ref_clk_i,
    input wire logic busy_i,
    output logic config_clock_o,
    output logic cs_n_o,
    output logic write_n_o,
    output logic [7:0] config_data_byte_o
);
    // 320 ns link clock, stands low between frames
    localparam int HALF = 4;
    initial
    begin
        config_clock_o = 1'b0;
        cs_n_o = 1'b1;
        write_n_o = 1'b1;
        config_data_byte_o = 8'h00;
    end
    task automatic pulse();
        repeat (HALF) @(negedge ref_clk_i);
        config_clock_o = 1'b1;
        repeat (HALF) @(negedge ref_clk_i);
        config_clock_o = 1'b0;
    endtask : pulse
    task automatic open_burst();
        @(negedge ref_clk_i);
        cs_n_o = 1'b0;
        write_n_o = 1'b0;
    endtask : open_burst
    task automatic send(input logic [7:0] b);
        int n;
        @(negedge ref_clk_i);
        config_data_byte_o = b;
        n = 0;
        // hold the byte while the port is busy
        while (busy_i === 1'b1 && n < 64)
        begin
            @(negedge ref_clk_i);
            n++;
        end
        pulse();
    endtask : send
    task automatic abort_write();
        @(negedge ref_clk_i);
        write_n_o = 1'b1;
        pulse();
    endtask : abort_write
    task automatic close_burst();
        @(negedge ref_clk_i);
        cs_n_o = 1'b1;
        write_n_o = 1'b1;
        config_data_byte_o = ~config_data_byte_o;
    endtask : close_burst
endmodule : pcwp_host_model

// [sim/tb.sv]
// tb: self-checking bench for pcwp_port
// assumes: host model owns the pins, bench watches outputs
`timescale 1ns/1ps
module tb;
    localparam int unsigned ABORT_CYC = pcwp_pkg::ABORT_CYC_RST;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic config_clock, cs_n, wr_n, busy, vld, algn, abrt;
    logic [7:0] din, dout;
    logic [7:0] got[$];
    logic [7:0] aborts = 8'h00;
    logic [7:0] busy_cyc = 8'h00;
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    always #20 ref_clk_i = ~ref_clk_i;
    pcwp_port DUT (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .config_clock_i(config_clock), .cs_n_i(cs_n), .write_n_i(wr_n),
        .config_data_byte_i(din), .busy_o(busy), .byte_valid_o(vld),
        .byte_data_o(dout), .aligned_o(algn), .abort_o(abrt));
    pcwp_host_model host (.ref_clk_i(ref_clk_i), .busy_i(busy),
        .config_clock_o(config_clock), .cs_n_o(cs_n), .write_n_o(wr_n),
        .config_data_byte_o(din));
    always @(posedge ref_clk_i)
    begin
        if (vld === 1'b1) got.push_back(dout);
        if (abrt === 1'b1) aborts <= aborts + 8'h01;
        if (busy === 1'b1) busy_cyc <= busy_cyc + 8'h01;
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            errors++;
            print_verdict();
        end
    end
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s exp %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    task automatic sync_word();
        for (int i = 3; i >= 0; i--)
            host.send(pcwp_pkg::SYNC_WORD_RST[8*i +: 8]);
        repeat (8) @(negedge ref_clk_i);
    endtask : sync_word
    task automatic take(input logic [7:0] exp);
        check("byte", got.size() > 0 ? got.pop_front() : 8'hxx, exp);
    endtask : take
    task automatic scn_stream();
        host.open_burst();
        sync_word();
        check("early", 8'(got.size()), 8'h00);
        check("aligned", {7'h00, algn}, 8'h01);
        host.send(8'h00);
        host.send(8'hff);
        host.send(8'ha5);
        repeat (8) @(negedge ref_clk_i);
        take(8'h00);
        take(8'hff);
        take(8'ha5);
        check("busy", busy_cyc, 8'h00);
        host.close_burst();
    endtask : scn_stream
    task automatic scn_abort();
        host.open_burst();
        // still aligned from the stream, so no second sync word here
        check("kept", {7'h00, algn}, 8'h01);
        host.send(8'h3c);
        host.abort_write();
        repeat (12) @(negedge ref_clk_i);
        take(8'h3c);
        check("aborts", aborts, 8'h01);
        check("unalign", {7'h00, algn}, 8'h00);
        check("busy", busy_cyc, 8'(ABORT_CYC));
        host.close_burst();
        host.open_burst();
        host.send(8'hc3);
        repeat (8) @(negedge ref_clk_i);
        check("refused", 8'(got.size()), 8'h00);
        sync_word();
        host.send(8'h5a);
        repeat (8) @(negedge ref_clk_i);
        take(8'h5a);
        host.close_burst();
    endtask : scn_abort
    initial
    begin
        repeat (10) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        scn_stream();
        scn_abort();
        print_verdict();
    end
endmodule : tb
